/* File: hdl/multiphase_fault_supervisor.sv */
// fault supervision for a multiphase buck controller
// assumes analogue comparators and soft-start live outside; cmp_i and chan_oc_i are resynchronised here, other inputs sync to clk_i
`timescale 1ns/100ps
`include "fault_supervisor_defines.svh"

module multiphase_fault_supervisor #(
    parameter int CHANNELS = 6,
    parameter int HICCUP_COUNT = `HICCUP_CYCLES,
    parameter int PG_DELAY = `PG_DELAY_CYCLES
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic clk_en_i,
    input wire logic power_enable_in_i,
    input wire logic termination_enable_in_i,
    input wire logic vid_valid_i,
    input wire logic vid_off_i,
    input wire logic softstart_done_i,
    input wire logic switch_cycle_i,
    input wire fault_supervisor_pkg::cmp_s cmp_i,
    input wire logic [CHANNELS-1:0] chan_oc_i,
    input wire logic [CHANNELS-1:0] pwm_raw_i,
    output logic power_good_out_o,
    output logic overtemp_flag_out_o,
    output logic softstart_run_o,
    output logic [CHANNELS-1:0] pwm_o,
    output logic [CHANNELS-1:0] pwm_oe_o
);

    ////////////////////////////////////////////////////////////////////////////
    // input synchronisers
    fault_supervisor_pkg::cmp_s cmp_meta_q;
    fault_supervisor_pkg::cmp_s cmp_q;
    logic [CHANNELS-1:0] choc_meta_q;
    logic [CHANNELS-1:0] choc_q;

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cmp_meta_q <= '0;
            cmp_q <= '0;
            choc_meta_q <= '0;
            choc_q <= '0;
        end else if (clk_en_i) begin
            cmp_meta_q <= cmp_i;
            cmp_q <= cmp_meta_q;
            choc_meta_q <= chan_oc_i;
            choc_q <= choc_meta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // decode
    fault_supervisor_pkg::sup_state_e state_q;
    fault_supervisor_pkg::sup_state_e state_d;
    logic vid_seen_q;
    logic uv_q;
    logic ov_drive_q;
    logic [12:0] hic_q;
    logic [12:0] pgd_q;
    logic [CHANNELS-1:0] chlim_q;

    wire enabled = power_enable_in_i && termination_enable_in_i;
    wire disable_req = !enabled || vid_off_i;
    // fixed threshold until a valid code is seen
    wire ov_trip = vid_seen_q ? cmp_q.ov_vid : cmp_q.ov_fixed;
    wire oc_trip = cmp_q.oc_avg || cmp_q.oc_current_monitor_pin;
    wire hic_done = (hic_q == 13'(HICCUP_COUNT - 1)) && switch_cycle_i;
    wire pgd_done = (pgd_q == 13'(PG_DELAY - 1));
    wire uv_next = cmp_q.uv_below_50 ? 1'b1 : (cmp_q.uv_above_60 ? 1'b0 : uv_q);
    wire in_run = (state_q == fault_supervisor_pkg::ST_RUN);
    wire pg_next = in_run && !uv_next && !oc_trip && !ov_trip && !disable_req;

    ////////////////////////////////////////////////////////////////////////////
    // sequencing
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            fault_supervisor_pkg::ST_OFF: begin
                if (!disable_req) begin
                    state_d = fault_supervisor_pkg::ST_SOFTSTART;
                end
            end
            fault_supervisor_pkg::ST_SOFTSTART: begin
                if (softstart_done_i) begin
                    state_d = fault_supervisor_pkg::ST_PG_WAIT;
                end
            end
            fault_supervisor_pkg::ST_PG_WAIT: begin
                if (pgd_done) begin
                    state_d = fault_supervisor_pkg::ST_RUN;
                end
            end
            fault_supervisor_pkg::ST_RUN: begin
            end
            fault_supervisor_pkg::ST_OC_WAIT: begin
                if (hic_done) begin
                    state_d = fault_supervisor_pkg::ST_SOFTSTART;
                end
            end
            fault_supervisor_pkg::ST_OV_LATCH: begin
            end
        endcase
        if (state_q != fault_supervisor_pkg::ST_OFF && state_q != fault_supervisor_pkg::ST_OC_WAIT
            && state_q != fault_supervisor_pkg::ST_OV_LATCH && oc_trip) begin
            state_d = fault_supervisor_pkg::ST_OC_WAIT;
        end
        if (disable_req && state_q != fault_supervisor_pkg::ST_OV_LATCH) begin
            state_d = fault_supervisor_pkg::ST_OFF;
        end
        if (state_q == fault_supervisor_pkg::ST_OV_LATCH && !enabled) begin
            state_d = fault_supervisor_pkg::ST_OFF;
        end
        if (ov_trip) begin
            state_d = fault_supervisor_pkg::ST_OV_LATCH;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_q <= fault_supervisor_pkg::ST_OFF;
        end else if (clk_en_i) begin
            state_q <= state_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // counters and fault levels
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            hic_q <= '0;
            pgd_q <= '0;
            vid_seen_q <= 1'b0;
            uv_q <= 1'b0;
            ov_drive_q <= 1'b0;
        end else if (clk_en_i) begin
            if (state_q != fault_supervisor_pkg::ST_OC_WAIT) begin
                hic_q <= '0;
            end else if (switch_cycle_i) begin
                hic_q <= hic_q + 13'h1;
            end
            pgd_q <= (state_q == fault_supervisor_pkg::ST_PG_WAIT) ? pgd_q + 13'h1 : 13'h0;
            if (!enabled) begin
                vid_seen_q <= 1'b0;
            end else if (vid_valid_i) begin
                vid_seen_q <= 1'b1;
            end
            uv_q <= uv_next;
            if (ov_trip) begin
                ov_drive_q <= 1'b1;
            end else if (cmp_q.ov_clear) begin
                ov_drive_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // per-channel peak limit
    for (genvar g = 0; g < CHANNELS; g++) begin : g_chan
        always_ff @(posedge clk_i or negedge reset_n_i) begin
            if (!reset_n_i) begin
                chlim_q[g] <= 1'b0;
            end else if (clk_en_i) begin
                if (switch_cycle_i) begin
                    chlim_q[g] <= choc_q[g];
                end else if (choc_q[g]) begin
                    chlim_q[g] <= 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    wire ov_now = state_d == fault_supervisor_pkg::ST_OV_LATCH;
    wire run_pwm = (state_d == fault_supervisor_pkg::ST_SOFTSTART)
        || (state_d == fault_supervisor_pkg::ST_PG_WAIT) || (state_d == fault_supervisor_pkg::ST_RUN);
    wire ov_low = ov_now && (ov_drive_q || ov_trip) && !(cmp_q.ov_clear && !ov_trip);
    wire [CHANNELS-1:0] pwm_d = run_pwm ? (pwm_raw_i & ~chlim_q & ~choc_q) : '0;
    wire [CHANNELS-1:0] oe_d = ov_low ? '1 : (run_pwm ? '1 : '0);
    wire tm_next = cmp_q.tm_below_low ? 1'b1 : (cmp_q.tm_above_high ? 1'b0 : overtemp_flag_out_o);

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            power_good_out_o <= 1'b0;
            overtemp_flag_out_o <= 1'b0;
            softstart_run_o <= 1'b0;
            pwm_o <= '0;
            pwm_oe_o <= '0;
        end else if (clk_en_i) begin
            power_good_out_o <= pg_next;
            overtemp_flag_out_o <= enabled && tm_next;
            softstart_run_o <= (state_d == fault_supervisor_pkg::ST_SOFTSTART);
            pwm_o <= ov_low ? '0 : pwm_d;
            pwm_oe_o <= oe_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    a_ov_pwm_low: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        clk_en_i && ov_trip |=> pwm_oe_o == '1 && pwm_o == '0)
        else $error("overvoltage did not force pwm low");
    a_oc_highz: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        clk_en_i && oc_trip && !ov_trip && state_q == fault_supervisor_pkg::ST_RUN
        |=> pwm_oe_o == '0)
        else $error("overcurrent did not float pwm");
    a_pg_fault_low: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        clk_en_i && (ov_trip || oc_trip || disable_req) |=> !power_good_out_o)
        else $error("power good high during fault");
    a_ov_latch_hold: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        state_q == fault_supervisor_pkg::ST_OV_LATCH && enabled
        |=> state_q == fault_supervisor_pkg::ST_OV_LATCH)
        else $error("overvoltage latch left while enabled");
    a_hiccup_retry: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        clk_en_i && state_q == fault_supervisor_pkg::ST_OC_WAIT && hic_done && !disable_req
        && !ov_trip |=> state_q == fault_supervisor_pkg::ST_SOFTSTART)
        else $error("no retry after hiccup wait");
    a_pg_delay_wait: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        $rose(state_q == fault_supervisor_pkg::ST_RUN) |-> $past(pgd_done))
        else $error("power good released before delay");
    a_temp_disabled: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        clk_en_i && !enabled |=> !overtemp_flag_out_o)
        else $error("overtemp flag while disabled");
    a_chan_limit: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        clk_en_i && !ov_trip ##1 clk_en_i && choc_q[0] |=> !pwm_o[0])
        else $error("channel limit not applied");

    ////////////////////////////////////////////////////////////////////////////
    // checks on sequencing, thresholds, the hiccup wait, channel limits and clock enable

    a_pg_needs_run: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        power_good_out_o
        |-> $past(state_q == fault_supervisor_pkg::ST_RUN))
        else $error("power good high without run");

    a_pg_idle_low: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        state_q != fault_supervisor_pkg::ST_RUN
        |-> !power_good_out_o)
        else $error("power good high outside run");

    a_uv_pg_low: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        clk_en_i && cmp_q.uv_below_50
        |=> !power_good_out_o)
        else $error("power good high under undervoltage");

    a_uv_recover: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        clk_en_i && uv_q && !cmp_q.uv_above_60
        |=> !power_good_out_o)
        else $error("power good back before recovery level");

    a_ov_fixed_level: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        clk_en_i && !vid_seen_q && cmp_q.ov_fixed
        |=> state_q == fault_supervisor_pkg::ST_OV_LATCH)
        else $error("fixed overvoltage level ignored");

    a_ov_code_level: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        clk_en_i && vid_seen_q && cmp_q.ov_vid
        |=> state_q == fault_supervisor_pkg::ST_OV_LATCH)
        else $error("code based overvoltage level ignored");

    a_ov_recur_low: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        clk_en_i && state_q == fault_supervisor_pkg::ST_OV_LATCH && !ov_drive_q && ov_trip
        |=> pwm_oe_o == '1 && pwm_o == '0)
        else $error("recurring overvoltage did not force pwm low");

    a_ov_float: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        clk_en_i && state_d == fault_supervisor_pkg::ST_OV_LATCH && !ov_trip && cmp_q.ov_clear
        |=> pwm_oe_o == '0)
        else $error("pwm not floated after overvoltage cleared");

    a_ov_no_restart: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        state_q == fault_supervisor_pkg::ST_OV_LATCH
        |-> !softstart_run_o && !power_good_out_o)
        else $error("normal operation during overvoltage latch");

    a_ov_code_change: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        clk_en_i && state_q == fault_supervisor_pkg::ST_OV_LATCH && enabled && vid_valid_i
        |=> state_q == fault_supervisor_pkg::ST_OV_LATCH)
        else $error("code change left overvoltage latch");

    a_oc_enter: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        clk_en_i && oc_trip && !ov_trip && !disable_req
        && state_q == fault_supervisor_pkg::ST_SOFTSTART
        |=> state_q == fault_supervisor_pkg::ST_OC_WAIT)
        else $error("overcurrent did not start shutdown");

    a_hiccup_hold: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        clk_en_i && state_q == fault_supervisor_pkg::ST_OC_WAIT && !hic_done
        && !ov_trip && !disable_req
        |=> state_q == fault_supervisor_pkg::ST_OC_WAIT && pwm_oe_o == '0)
        else $error("hiccup wait ended early");

    a_hiccup_count: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        clk_en_i && state_q == fault_supervisor_pkg::ST_OC_WAIT && !switch_cycle_i
        |=> $stable(hic_q))
        else $error("hiccup counted without switching pulse");

    a_chan_release: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        clk_en_i && switch_cycle_i && !choc_q[0]
        |=> !chlim_q[0])
        else $error("channel limit held past cycle end");

    a_chan_no_trip: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        clk_en_i && state_q == fault_supervisor_pkg::ST_RUN && !oc_trip && !ov_trip && !disable_req
        |=> state_q == fault_supervisor_pkg::ST_RUN)
        else $error("run left without converter fault");

    a_temp_set: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        clk_en_i && enabled && cmp_q.tm_below_low
        |=> overtemp_flag_out_o)
        else $error("overtemp flag not set");

    a_temp_clear: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        clk_en_i && cmp_q.tm_above_high && !cmp_q.tm_below_low
        |=> !overtemp_flag_out_o)
        else $error("overtemp flag not cleared");

    a_clken_freeze: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        !clk_en_i
        |=> $stable(state_q) && $stable(pwm_oe_o) && $stable(power_good_out_o))
        else $error("state moved with clock enable low");

endmodule : multiphase_fault_supervisor

/* File: hdl/fault_supervisor_defines.svh */
// timing counts and widths for the fault supervisor
// assumes a 40 MHz controller clock
`ifndef FAULT_SUPERVISOR_DEFINES_SVH
`define FAULT_SUPERVISOR_DEFINES_SVH

`define CLK_PERIOD_PS 25000
`define PG_DELAY_NS 85000
`define PG_DELAY_CYCLES ((`PG_DELAY_NS * 1000) / `CLK_PERIOD_PS)
`define HICCUP_CYCLES 4096
`define PWM_LOW 2'h0
`define PWM_HIGHZ 2'h1
`define PWM_RUN 2'h2

`endif

/* File: hdl/fault_supervisor_pkg.sv */
// types shared by the fault supervisor
// assumes comparator results arrive as plain levels
package fault_supervisor_pkg;

    typedef enum logic [2:0] {
        ST_OFF,
        ST_SOFTSTART,
        ST_PG_WAIT,
        ST_RUN,
        ST_OC_WAIT,
        ST_OV_LATCH
    } sup_state_e;

    typedef struct packed {
        logic uv_below_50;
        logic uv_above_60;
        logic ov_fixed;
        logic ov_vid;
        logic ov_clear;
        logic oc_avg;
        logic oc_current_monitor_pin;
        logic tm_below_low;
        logic tm_above_high;
    } cmp_s;

endpackage : fault_supervisor_pkg

/* File: verif/gate_driver_model.sv */
// model of the switch drivers on each pwm line
// assumes one pwm bit and one drive enable per channel from the supervisor
`timescale 1ns/100ps
module gate_driver_model #(
    parameter int CHANNELS = 6
) (
    input wire logic [CHANNELS-1:0] pwm_i,
    input wire logic [CHANNELS-1:0] pwm_oe_i,
    output logic [CHANNELS-1:0] upper_on_o,
    output logic [CHANNELS-1:0] lower_on_o
);
    // floated input turns both switches off
    assign upper_on_o = pwm_oe_i & pwm_i;
    assign lower_on_o = pwm_oe_i & ~pwm_i;
endmodule : gate_driver_model

/* File: verif/testbench.sv */
// self-checking bench for the fault supervisor
// assumes a 40 MHz clock and shortened hiccup and power good counts
`timescale 1ns/100ps
module testbench;
    localparam int CH = 6;
    localparam int HIC = 8;
    localparam int PGD = 10;
    localparam logic [CH-1:0] ALL = '1;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic power_enable_in = 1'b0;
    logic en_tt = 1'b0;
    logic vid_valid = 1'b0;
    logic clk_en = 1'b1;
    logic [CH-1:0] held;
    logic vid_off = 1'b0;
    logic ss_done = 1'b0;
    logic sw_pulse = 1'b0;
    fault_supervisor_pkg::cmp_s cmp = '0;
    logic [CH-1:0] chan_oc = '0;
    logic [CH-1:0] pwm_raw = '0;
    logic pg, hot, ss_run;
    logic [CH-1:0] pwm, oe, up_on, lo_on;
    logic [31:0] seed = 32'hf87ba18b;
    int err_total = 0;
    int total_checks = 0;
    always #12.5 clk_i = ~clk_i;
    multiphase_fault_supervisor #(.CHANNELS(CH), .HICCUP_COUNT(HIC), .PG_DELAY(PGD))
        multiphase_fault_supervisor_inst (.clk_i(clk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en),
        .power_enable_in_i(power_enable_in), .termination_enable_in_i(en_tt), .vid_valid_i(vid_valid),
        .vid_off_i(vid_off), .softstart_done_i(ss_done), .switch_cycle_i(sw_pulse),
        .cmp_i(cmp), .chan_oc_i(chan_oc), .pwm_raw_i(pwm_raw), .power_good_out_o(pg),
        .overtemp_flag_out_o(hot), .softstart_run_o(ss_run), .pwm_o(pwm), .pwm_oe_o(oe));
    gate_driver_model #(.CHANNELS(CH)) gate_driver_model_inst (.pwm_i(pwm), .pwm_oe_i(oe),
        .upper_on_o(up_on), .lower_on_o(lo_on));
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] v;
        v = s ^ (s << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction : xs
    function automatic logic [CH-1:0] exp_pwm(input logic [CH-1:0] raw, input logic [CH-1:0] lim);
        return raw & ~lim;
    endfunction : exp_pwm
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : step
    task automatic pulses(input int n);
        repeat (n) begin
            @(posedge clk_i) sw_pulse <= 1'b1;
            @(posedge clk_i) sw_pulse <= 1'b0;
        end
    endtask : pulses
    task automatic start_up;
        @(posedge clk_i) {power_enable_in, en_tt} <= 2'h3;
        step(2);
        chk(ss_run, 1);
        @(posedge clk_i) {ss_done, vid_valid} <= 2'h3;
        @(posedge clk_i) ss_done <= 1'b0;
        step(PGD - 3);
        chk(pg, 0);
        step(6);
        chk(pg, 1);
    endtask : start_up
    task automatic end_sim;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_sim
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #(25 * 4000);
        err_total++;
        end_sim();
    end
    initial begin
        repeat (4) @(posedge clk_i);
        reset_n_i <= 1'b1;
        step(1);
        chk({pg, hot, oe}, 0);
        // overvoltage while disabled, fixed threshold
        @(posedge clk_i) cmp.ov_fixed <= 1'b1;
        step(4);
        chk(lo_on, ALL);
        @(posedge clk_i) {cmp.ov_fixed, cmp.ov_clear} <= 2'h1;
        step(4);
        chk(up_on | lo_on | oe, 0);
        @(posedge clk_i) {cmp.ov_fixed, cmp.ov_clear} <= 2'h2;
        step(4);
        chk(lo_on, ALL);
        @(posedge clk_i) vid_valid <= 1'b1;
        @(posedge clk_i) vid_valid <= 1'b0;
        step(2);
        chk(lo_on, ALL);
        @(posedge clk_i) {cmp.ov_fixed, cmp.ov_clear} <= 2'h1;
        @(posedge clk_i) {power_enable_in, en_tt} <= 2'h3;
        step(4);
        chk({ss_run, pg}, 0);
        @(posedge clk_i) {en_tt, cmp.ov_clear} <= 2'h0;
        step(2);
        start_up();
        // random modulator traffic passes through in run
        repeat (20) begin
            seed = xs(seed);
            @(posedge clk_i) pwm_raw <= seed[CH-1:0];
            step(1);
            chk(pwm, exp_pwm(seed[CH-1:0], '0));
        end
        // clock enable low freezes every register
        held = pwm;
        @(posedge clk_i) {clk_en, pwm_raw} <= {1'b0, ~held};
        step(3);
        chk(pwm, held);
        @(posedge clk_i) clk_en <= 1'b1;
        step(1);
        chk(pwm, exp_pwm(~held, '0));
        @(posedge clk_i) {pwm_raw, chan_oc} <= {ALL, 6'h05};
        step(4);
        chk(pwm, exp_pwm(ALL, 6'h05));
        chk({pg, oe}, {1'b1, ALL});
        @(posedge clk_i) chan_oc <= '0;
        step(3);
        chk(pwm, exp_pwm(ALL, 6'h05));
        pulses(1);
        step(2);
        chk(pwm, ALL);
        @(posedge clk_i) cmp.uv_below_50 <= 1'b1;
        step(4);
        chk(pg, 0);
        @(posedge clk_i) cmp.uv_below_50 <= 1'b0;
        step(4);
        chk(pg, 0);
        @(posedge clk_i) cmp.uv_above_60 <= 1'b1;
        step(4);
        chk(pg, 1);
        @(posedge clk_i) cmp.tm_below_low <= 1'b1;
        step(4);
        chk(hot, 1);
        @(posedge clk_i) cmp.tm_below_low <= 1'b0;
        step(4);
        chk(hot, 1);
        @(posedge clk_i) cmp.tm_above_high <= 1'b1;
        step(4);
        chk(hot, 0);
        @(posedge clk_i) {cmp.tm_above_high, cmp.tm_below_low, vid_off} <= 3'h3;
        step(4);
        chk(pg, 0);
        @(posedge clk_i) {power_enable_in, vid_off} <= 2'h0;
        step(2);
        chk({hot, pg}, 0);
        @(posedge clk_i) cmp.tm_below_low <= 1'b0;
        start_up();
        // overcurrent trip and hiccup retry
        @(posedge clk_i) cmp.oc_avg <= 1'b1;
        step(4);
        chk({oe, pg}, 0);
        @(posedge clk_i) cmp.oc_avg <= 1'b0;
        pulses(HIC - 1);
        step(2);
        chk(ss_run, 0);
        pulses(2);
        step(2);
        chk(ss_run, 1);
        @(posedge clk_i) cmp.oc_current_monitor_pin <= 1'b1;
        step(4);
        chk(oe, 0);
        @(posedge clk_i) {cmp.oc_current_monitor_pin, cmp.ov_vid} <= 2'h1;
        step(4);
        chk(lo_on, ALL);
        // overvoltage handling while enabled, then power-on reset clears the latch
        @(posedge clk_i) {cmp.ov_vid, cmp.ov_clear} <= 2'h1;
        step(4);
        chk({oe, ss_run, pg}, 0);
        @(posedge clk_i) {cmp.ov_vid, cmp.ov_clear} <= 2'h2;
        step(4);
        chk({lo_on, ss_run}, {ALL, 1'b0});
        @(posedge clk_i) {cmp.ov_vid, reset_n_i} <= 2'h0;
        @(posedge clk_i) reset_n_i <= 1'b1;
        step(0);
        chk({pg, oe, ss_run}, 0);
        step(1);
        chk({ss_run, oe}, {1'b1, ALL});
        end_sim();
    end
endmodule : testbench
